// *** verif/tb_uart_line_modem_control.sv ***
// Bench for the UART line and modem control block: APB register tests and frame checks.
// Assumes the remote model on txd/rxd and a divisor of one, so a bit lasts 16 pclk cycles.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_uart_line_modem_control
	import ulmc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, ring_indicator_in, err, rxd, txd, pready, pslverr;
	logic terminal_ready_n, request_send_n, spare_output_two_n, irq_out_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int failures = 0;
	int cmp_count = 0;

	always #50 pclk = ~pclk;

	ulmc_top u_ulmc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
		.txd(txd), .ring_indicator_in(ring_indicator_in), .terminal_ready_n(terminal_ready_n),
		.request_send_n(request_send_n), .spare_output_two_n(spare_output_two_n), .irq_out_en(irq_out_en));
	ulmc_remote u_ulmc_remote (.pclk(pclk), .txd(txd), .rxd(rxd));

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic hang();
		failures++;
		results();
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		`CHK(rd & m, e)
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		do apb(ULMC_ADDR_LSTAT, 1'b0, 32'h0); while (rd[6] !== 1'b1 && ++k < 400);
		if (k >= 400)
			hang();
	endtask

	// Start bit, data LSB first, parity (inverted when flip is set), then idle-high stop
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] lc, input logic flip);
		int n;
		logic [7:0] m;
		n = 5 + int'(lc[1:0]);
		m = d & ~(8'hFF << n);
		frame = '1;
		frame[0] = 1'b0;
		for (int i = 0; i < n; i++)
			frame[i + 1] = d[i];
		if (lc[3])
			frame[n + 1] = flip ^ (lc[5] ? ~lc[4] : (lc[4] ? ^m : ~^m));
	endfunction

	function automatic int flen(input logic [7:0] lc);
		return 7 + int'(lc[1:0]) + int'(lc[3]);
	endfunction

	// Start-to-start spacing in 16x ticks
	function automatic int plen(input logic [7:0] lc);
		return 16 * (flen(lc) - 1) + (!lc[2] ? 16 : (lc[1:0] == 2'h0 ? 24 : 32));
	endfunction

	task automatic t_reset();
		`CHK({txd, terminal_ready_n, request_send_n, spare_output_two_n, irq_out_en}, 5'h1E)
		rchk(ULMC_ADDR_LINE, 32'hFFFFFFFF, 32'h0);
		rchk(ULMC_ADDR_MODEM, 32'hFFFFFFFF, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_pins();
		logic [7:0] v [3] = '{8'h01, 8'h02, 8'h08};
		logic [3:0] e [3] = '{4'h6, 4'hA, 4'hD};
		for (int i = 0; i < 3; i++)
		begin
			wr(ULMC_ADDR_MODEM, {24'h0, v[i]});
			repeat (2) @(posedge pclk);
			`CHK({terminal_ready_n, request_send_n, spare_output_two_n, irq_out_en}, e[i])
			rchk(ULMC_ADDR_MODEM, 32'hFF, {24'h0, v[i]});
		end
		wr(ULMC_ADDR_MODEM, 32'h0);
		$display("modem pin test done");
	endtask

	task automatic t_divisor();
		wr(ULMC_ADDR_LINE, 32'h80);
		wr(ULMC_ADDR_DATA, 32'h01);
		wr(ULMC_ADDR_FIFO, 32'h00);
		rchk(ULMC_ADDR_DATA, 32'hFF, 32'h01);
		wr(ULMC_ADDR_LINE, 32'h00);
		apb(8'h24, 1'b0, 32'h0);
		`CHK(err, 1'b1)
		$display("divisor test done");
	endtask

	task automatic tx_pair(input logic [7:0] lc, input logic pre);
		logic [11:0] b1, b2;
		realtime t1;
		int per;
		u_ulmc_remote.bit_cyc = pre ? 64 : 16;
		wr(ULMC_ADDR_MODEM, {24'h0, pre, 7'h0});
		wr(ULMC_ADDR_LINE, {24'h0, lc});
		fork
			begin
				wr(ULMC_ADDR_DATA, 32'hA5);
				wr(ULMC_ADDR_DATA, 32'h3C);
			end
			begin
				u_ulmc_remote.grab(flen(lc), b1);
				t1 = u_ulmc_remote.t_fall;
				u_ulmc_remote.grab(flen(lc), b2);
			end
		join
		// Spacing in pclk cycles against the nominal; a frame starts off the tick grid,
		// so its start bit may be short by up to one tick less a cycle
		per = int'((u_ulmc_remote.t_fall - t1) / 100.0) - plen(lc) * u_ulmc_remote.bit_cyc / 16;
		`CHK(b1, frame(8'hA5, lc, 1'b0))
		`CHK(b2, frame(8'h3C, lc, 1'b0))
		`CHK(per > -u_ulmc_remote.bit_cyc / 16 && per <= 4, 1'b1)
		wait_idle();
	endtask

	task automatic t_format();
		tx_pair(8'h00, 1'b0);
		tx_pair(8'h04, 1'b0);
		tx_pair(8'h07, 1'b0);
		tx_pair(8'h09, 1'b0);
		tx_pair(8'h1A, 1'b0);
		tx_pair(8'h2B, 1'b0);
		tx_pair(8'h3B, 1'b0);
		tx_pair(8'h0E, 1'b1);
		$display("transmit format test done");
	endtask

	task automatic t_receive();
		u_ulmc_remote.bit_cyc = 16;
		wr(ULMC_ADDR_MODEM, 32'h0);
		wr(ULMC_ADDR_LINE, 32'h1B);
		u_ulmc_remote.send(frame(8'h5A, 8'h1B, 1'b0), flen(8'h1B));
		rchk(ULMC_ADDR_LSTAT, 32'h5, 32'h1);
		rchk(ULMC_ADDR_DATA, 32'hFF, 32'h5A);
		rchk(ULMC_ADDR_LSTAT, 32'h1, 32'h0);
		u_ulmc_remote.send(frame(8'h5A, 8'h1B, 1'b1), flen(8'h1B));
		rchk(ULMC_ADDR_LSTAT, 32'h5, 32'h5);
		rchk(ULMC_ADDR_DATA, 32'hFF, 32'h5A);
		wr(ULMC_ADDR_LINE, 32'h00);
		u_ulmc_remote.send(frame(8'h13, 8'h00, 1'b0), flen(8'h00));
		rchk(ULMC_ADDR_DATA, 32'h1F, 32'h13);
		$display("receive test done");
	endtask

	task automatic t_break();
		wr(ULMC_ADDR_LINE, 32'h43);
		repeat (40) @(posedge pclk);
		`CHK(txd, 1'b0)
		wr(ULMC_ADDR_LINE, 32'h03);
		repeat (3) @(posedge pclk);
		`CHK(txd, 1'b1)
		wr(ULMC_ADDR_MODEM, 32'h40);
		repeat (3) @(posedge pclk);
		`CHK(txd, 1'b0)
		wr(ULMC_ADDR_MODEM, 32'h00);
		repeat (3) @(posedge pclk);
		`CHK(txd, 1'b1)
		$display("break and infrared test done");
	endtask

	task automatic t_loopback();
		ring_indicator_in <= 1'b0;
		repeat (4) @(posedge pclk);
		rchk(ULMC_ADDR_MSTAT, 32'h40, 32'h40);
		wr(ULMC_ADDR_MODEM, 32'h13);
		rchk(ULMC_ADDR_MSTAT, 32'h40, 32'h00);
		`CHK({txd, terminal_ready_n}, 2'h3)
		wr(ULMC_ADDR_MODEM, 32'h14);
		rchk(ULMC_ADDR_MSTAT, 32'h40, 32'h40);
		wr(ULMC_ADDR_DATA, 32'h66);
		wait_idle();
		rchk(ULMC_ADDR_DATA, 32'hFF, 32'h66);
		wr(ULMC_ADDR_MODEM, 32'h00);
		ring_indicator_in <= 1'b1;
		$display("loopback test done");
	endtask

	// Off character halts transmit; any other character resumes it; flow characters are not stored
	task automatic t_flow();
		wr(ULMC_ADDR_LINE, 32'h03);
		wr(ULMC_ADDR_FEAT, 32'h08);
		wr(ULMC_ADDR_FLOW, 32'h00131101);
		u_ulmc_remote.send(frame(8'h13, 8'h03, 1'b0), flen(8'h03));
		wr(ULMC_ADDR_DATA, 32'h55);
		rchk(ULMC_ADDR_LSTAT, 32'h61, 32'h0);
		wr(ULMC_ADDR_MODEM, 32'h20);
		u_ulmc_remote.send(frame(8'h41, 8'h03, 1'b0), flen(8'h03));
		rchk(ULMC_ADDR_LSTAT, 32'h61, 32'h21);
		`CHK(request_send_n, 1'b0)
		u_ulmc_remote.send(frame(8'h11, 8'h03, 1'b0), flen(8'h03));
		rchk(ULMC_ADDR_DATA, 32'hFF, 32'h41);
		rchk(ULMC_ADDR_LSTAT, 32'h3, 32'h0);
		wait_idle();
		`CHK(request_send_n, 1'b1)
		wr(ULMC_ADDR_FEAT, 32'h0);
		wr(ULMC_ADDR_FLOW, 32'h0);
		wr(ULMC_ADDR_MODEM, 32'h0);
		$display("flow resume test done");
	endtask

	task automatic t_trigger();
		logic [6:0] rx_t [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
		logic [6:0] tx_t [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
		wr(ULMC_ADDR_FEAT, 32'h20);
		for (int s = 3; s >= 0; s--)
		begin
			wr(ULMC_ADDR_FIFO, {24'h0, 2'(s), 2'(s), 4'h1});
			rchk(ULMC_ADDR_TRIG, 32'h7F7F00, {9'h0, tx_t[s], 1'b0, rx_t[s], 8'h0});
		end
		wr(ULMC_ADDR_FIFO, 32'hF0);
		rchk(ULMC_ADDR_TRIG, 32'h7F7F00, 32'h80800);
		wr(ULMC_ADDR_FEAT, 32'h30);
		wr(ULMC_ADDR_TRIG, 32'h05);
		wr(ULMC_ADDR_FEAT, 32'hB0);
		wr(ULMC_ADDR_TRIG, 32'h09);
		rchk(ULMC_ADDR_TRIG, 32'h7F7F00, 32'h90500);
		$display("trigger test done");
	endtask

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ring_indicator_in = 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_pins();
		t_divisor();
		t_format();
		t_receive();
		t_break();
		t_loopback();
		t_flow();
		t_trigger();
		`CHK(u_ulmc_remote.lost, 1'b0)
		results();
	end
endmodule // tb_uart_line_modem_control

// *** verif/ulmc_remote.sv ***
// Remote serial device at the far end of the line: sends frames on rxd and samples frames on txd.
// Assumes the bench sets bit_cyc to the bit time in pclk cycles before each use.
`timescale 1ns/10ps
module ulmc_remote
(
	// Clock
	input wire logic pclk,
	// Serial line
	input wire logic txd,
	output logic rxd
);
	int bit_cyc = 16;
	logic lost = 1'b0;
	realtime t_fall;

	// A marking line rests high between frames
	initial rxd = 1'b1;

	task automatic send(input logic [11:0] bits, input int n);
		@(posedge pclk);
		for (int i = 0; i < n; i++)
		begin
			rxd <= bits[i];
			repeat (bit_cyc) @(posedge pclk);
		end
		rxd <= 1'b1;
	endtask

	// Returns at mid of the last sampled bit, so the next start edge is never missed
	task automatic grab(input int n, output logic [11:0] bits);
		int k;
		k = 0;
		bits = '1;
		while (txd !== 1'b1 && k++ < 4000) @(posedge pclk);
		while (txd !== 1'b0 && k++ < 4000) @(posedge pclk);
		lost = lost | (k > 4000);
		t_fall = $realtime;
		repeat (bit_cyc / 2) @(posedge pclk);
		for (int i = 0; i < n; i++)
		begin
			if (i > 0)
				repeat (bit_cyc) @(posedge pclk);
			bits[i] = txd;
		end
	endtask
endmodule // ulmc_remote

// *** verilog/ulmc_pkg.sv ***
// Package for the UART line and modem control block: register map, field layouts, timing counts.
// Assumes a 16x oversampling bit clock derived inside the block from pclk.
package ulmc_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] ULMC_ADDR_DATA = 8'h00;
	localparam logic [7:0] ULMC_ADDR_FIFO = 8'h04;
	localparam logic [7:0] ULMC_ADDR_LINE = 8'h08;
	localparam logic [7:0] ULMC_ADDR_MODEM = 8'h0C;
	localparam logic [7:0] ULMC_ADDR_LSTAT = 8'h10;
	localparam logic [7:0] ULMC_ADDR_MSTAT = 8'h14;
	localparam logic [7:0] ULMC_ADDR_FEAT = 8'h18;
	localparam logic [7:0] ULMC_ADDR_TRIG = 8'h1C;
	localparam logic [7:0] ULMC_ADDR_FLOW = 8'h20;
	// Feature control fields
	localparam int ULMC_FEAT_TARGET = 7;
	localparam int ULMC_FEAT_HALF_DUPLEX = 3;
	localparam logic [1:0] ULMC_TBL_D = 2'h3;
	// Bit timing in 16x ticks; ULMC_BIT_TICKS and ULMC_IR_PULSE are tick counts, the others last indexes (ULMC_PRESC_LAST in pclk cycles)
	localparam logic [5:0] ULMC_BIT_TICKS = 6'h10;
	localparam logic [5:0] ULMC_BIT_LAST = 6'h0F;
	localparam logic [5:0] ULMC_MID_LAST = 6'h07;
	localparam logic [5:0] ULMC_STOP15_LAST = 6'h17;
	localparam logic [5:0] ULMC_STOP2_LAST = 6'h1F;
	localparam logic [5:0] ULMC_IR_PULSE = 6'h03;
	localparam logic [1:0] ULMC_PRESC_LAST = 2'h3;
	localparam logic [2:0] ULMC_WLEN_BASE = 3'h4;
	// Trigger tables A..C, indexed by the two-bit level field
	localparam logic [6:0] ULMC_RX_TRIG [4][4] = '{'{7'h01, 7'h04, 7'h08, 7'h0E}, '{7'h08, 7'h10, 7'h18, 7'h1C},
		'{7'h08, 7'h10, 7'h38, 7'h3C}, '{7'h00, 7'h00, 7'h00, 7'h00}};
	localparam logic [6:0] ULMC_TX_TRIG [4][4] = '{'{7'h01, 7'h01, 7'h01, 7'h01}, '{7'h10, 7'h08, 7'h18, 7'h1E},
		'{7'h08, 7'h10, 7'h20, 7'h38}, '{7'h00, 7'h00, 7'h00, 7'h00}};

	typedef struct packed {
		logic dlab;
		logic brk;
		logic pforce;
		logic peven;
		logic pen;
		logic stop_long;
		logic [1:0] wlen;
	} ulmc_line_t;

	typedef struct packed {
		logic presc;
		logic ir;
		logic any_resume;
		logic loop;
		logic op2;
		logic ring_loop;
		logic rts;
		logic dtr;
	} ulmc_modem_t;

	// Index of the last data bit
	function automatic logic [2:0] ulmc_last_bit(input ulmc_line_t l);
		return ULMC_WLEN_BASE + {1'b0, l.wlen};
	endfunction

	// Parity bit to send or expect; ones above the word length are ignored
	function automatic logic ulmc_parity(input logic [7:0] d, input ulmc_line_t l);
		logic [7:0] m;
		m = '0;
		for (int i = 0; i < 8; i++)
			m[i] = d[i] && (3'(i) <= ulmc_last_bit(l));
		if (l.pforce)
			return ~l.peven;
		return l.peven ? ^m : ~^m;
	endfunction

	function automatic logic [6:0] ulmc_trigger(input logic [1:0] tbl, input logic [1:0] sel,
		input logic [6:0] prog, input logic rx);
		if (tbl == ULMC_TBL_D)
			return prog;
		return rx ? ULMC_RX_TRIG[tbl][sel] : ULMC_TX_TRIG[tbl][sel];
	endfunction
endpackage

// *** verilog/ulmc_top.sv ***
// UART channel: line format, modem control pins, line status and receive FIFO behind APB.
// Assumes APB master on pclk; rxd and ring_indicator_in are asynchronous pins.
// Summary of operation
// RULE_01: Table C gives fixed receive/transmit trigger levels.
// RULE_02: Table D takes levels from programmable trigger register.
// RULE_03: Word length 5 to 8 bits.
// RULE_04: Stop bits one, one-and-half, or two.
// RULE_05: Parity enable appends and checks parity.
// RULE_06: Parity type selects odd or even.
// RULE_07: Forced parity fixes bit at mark/space.
// RULE_08: Break holds transmit line low.
// RULE_09: Divisor access bit remaps shared addresses.
// RULE_10: Terminal-ready pin is inverse of bit.
// RULE_11: Request-to-send pin inverse, unless auto direction.
// RULE_12: Bit 2 supplies ring state in loopback.
// RULE_13: Bit 3 enables interrupt outputs, spare low.
// RULE_14: Host keeps bit 3 clear on second bus.
// RULE_15: Loopback bit routes transmit into receiver.
// RULE_16: Any received character resumes halted transmit; the code halts again on the off character instead.
// RULE_17: Resuming character stored unless flow character.
// RULE_18: Infrared bit routes through pulse encoder/decoder.
// RULE_19: Infrared transmit output idles low.
// RULE_20: Prescaler bit divides clock by four.
// RULE_21: Data-ready shows receive FIFO not empty.
// RULE_22: Trigger fields written only with FIFO enable.
// RULE_23: Line and modem control reset to zero.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module ulmc_top
	import ulmc_pkg::*;
#(
	parameter int FIFO_DEPTH = 64
)
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line
	input wire logic rxd,
	output logic txd,
	// Modem pins, active low
	input wire logic ring_indicator_in,
	output logic terminal_ready_n,
	output logic request_send_n,
	output logic spare_output_two_n,
	// Interrupt pad driver enable
	output logic irq_out_en
);
	localparam int PW = $clog2(FIFO_DEPTH);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulmc_rx_st_t;
	typedef struct packed {
		logic rx_s1, rx_s2, ring_s1, ring_s2;
		logic [31:0] prdata;
		logic pready, pslverr;
		ulmc_line_t lc;
		ulmc_modem_t mc;
		logic fifo_en;
		logic [1:0] tx_sel, rx_sel;
		logic [7:0] feat;
		logic [6:0] prog_rx, prog_tx;
		logic sw_flow;
		logic [7:0] xon, xoff;
		logic [15:0] div;
		logic [1:0] pre_cnt;
		logic [15:0] baud_cnt;
		logic tick;
		logic [5:0] ir_hold;
		logic rx_in;
		ulmc_rx_st_t rx_st;
		logic [5:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [FIFO_DEPTH-1:0][7:0] mem;
		logic [PW-1:0] wr_ptr, rd_ptr;
		logic [PW:0] count;
		logic overrun, perr, ferr, brk_det, halted;
		logic thr_full;
		logic [7:0] thr;
		logic txd, dtr_n, rts_n, op2_n, irq_en;
	} ulmc_state_t;
	ulmc_state_t s_reg, s_next;

	logic tx_serial, tx_ir, tx_busy, tx_start, tx_line, pre_tick;
	logic setup, wr, rd, push, pop, flush;
	logic [6:0] rx_trig, tx_trig;
	logic [31:0] rdata;

	ulmc_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.tick(s_reg.tick),
		.start(tx_start),
		.data(s_reg.thr),
		.line(s_reg.lc),
		.serial(tx_serial),
		.ir_pulse(tx_ir),
		.busy(tx_busy)
	);

	always_comb
	begin
		s_next = s_reg;
		push = 1'b0;
		pop = 1'b0;
		flush = 1'b0;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		s_next.tick = 1'b0;
		s_next.rx_s1 = rxd;
		s_next.rx_s2 = s_reg.rx_s1;
		s_next.ring_s1 = ring_indicator_in;
		s_next.ring_s2 = s_reg.ring_s1;

		// Baud generation: optional divide by four, then the divisor
		pre_tick = !s_reg.mc.presc || s_reg.pre_cnt == ULMC_PRESC_LAST; // RULE_20
		s_next.pre_cnt = s_reg.pre_cnt + 2'h1;
		if (pre_tick && s_reg.div != '0)
		begin
			if (s_reg.baud_cnt >= s_reg.div - 16'h0001)
			begin
				s_next.baud_cnt = '0;
				s_next.tick = 1'b1;
			end
			else
				s_next.baud_cnt = s_reg.baud_cnt + 16'h0001;
		end

		// Stretch the short infrared pulse over a full bit so mid-bit sampling sees it
		if (s_reg.rx_s2)
			s_next.ir_hold = ULMC_BIT_TICKS;
		else if (s_reg.tick && s_reg.ir_hold != '0)
			s_next.ir_hold = s_reg.ir_hold - 6'h01;
		tx_line = s_reg.lc.brk ? 1'b0 : tx_serial;
		s_next.rx_in = s_reg.mc.loop ? tx_line : (s_reg.mc.ir ? s_reg.ir_hold == '0 : s_reg.rx_s2); // RULE_15 RULE_18

		// Transmit start; a halted transmitter waits for flow release
		tx_start = s_reg.thr_full && !tx_busy && !s_reg.halted;
		if (tx_start)
			s_next.thr_full = 1'b0;

		// APB: answer one cycle after setup, effects at the access edge
		setup = psel && !penable;
		wr = psel && penable && s_reg.pready && pwrite;
		rd = psel && penable && s_reg.pready && !pwrite;
		rx_trig = ulmc_trigger(s_reg.feat[5:4], s_reg.rx_sel, s_reg.prog_rx, 1'b1); // RULE_01 RULE_02
		tx_trig = ulmc_trigger(s_reg.feat[5:4], s_reg.tx_sel, s_reg.prog_tx, 1'b0); // RULE_01 RULE_02
		rdata = '0;
		s_next.pslverr = 1'b0;
		case (paddr)
			ULMC_ADDR_DATA: rdata[7:0] = s_reg.lc.dlab ? s_reg.div[7:0] : s_reg.mem[s_reg.rd_ptr]; // RULE_09
			ULMC_ADDR_FIFO: rdata[7:0] = s_reg.lc.dlab ? s_reg.div[15:8] : 8'h00;
			ULMC_ADDR_LINE: rdata[7:0] = s_reg.lc;
			ULMC_ADDR_MODEM: rdata[7:0] = s_reg.mc;
			ULMC_ADDR_LSTAT: rdata[7:0] = {s_reg.perr | s_reg.ferr | s_reg.brk_det, !s_reg.thr_full && !tx_busy,
				!s_reg.thr_full, s_reg.brk_det, s_reg.ferr, s_reg.perr, s_reg.overrun, s_reg.count != '0}; // RULE_21
			ULMC_ADDR_MSTAT: rdata[7:0] = {1'b0, s_reg.mc.loop ? s_reg.mc.ring_loop : !s_reg.ring_s2, 6'h00}; // RULE_12
			ULMC_ADDR_FEAT: rdata[7:0] = s_reg.feat;
			ULMC_ADDR_TRIG: rdata = {7'h00, int'(s_reg.count) >= int'(rx_trig), 1'b0, tx_trig, 1'b0, rx_trig,
				8'(s_reg.count)};
			ULMC_ADDR_FLOW: rdata = {8'h00, s_reg.xoff, s_reg.xon, 7'h00, s_reg.sw_flow};
			default: s_next.pslverr = setup;
		endcase
		if (setup)
		begin
			s_next.pready = 1'b1;
			s_next.prdata = rdata;
		end
		else
			s_next.pslverr = 1'b0;
		if (rd && paddr == ULMC_ADDR_DATA && !s_reg.lc.dlab && s_reg.count != '0)
			pop = 1'b1;
		if (rd && paddr == ULMC_ADDR_LSTAT)
		begin
			// Cleared here; a receive event later in this process still sets them
			s_next.overrun = 1'b0;
			s_next.perr = 1'b0;
			s_next.ferr = 1'b0;
			s_next.brk_det = 1'b0;
		end
		if (wr)
		begin
			case (paddr)
				ULMC_ADDR_DATA:
					if (s_reg.lc.dlab) // RULE_09
						s_next.div[7:0] = pwdata[7:0];
					else
					begin
						s_next.thr = pwdata[7:0];
						s_next.thr_full = 1'b1;
					end
				ULMC_ADDR_FIFO:
					if (s_reg.lc.dlab)
						s_next.div[15:8] = pwdata[7:0];
					else
					begin
						s_next.fifo_en = pwdata[0];
						if (pwdata[0]) // RULE_22
						begin
							s_next.tx_sel = pwdata[5:4];
							s_next.rx_sel = pwdata[7:6];
							flush = pwdata[1];
							if (pwdata[2])
								s_next.thr_full = 1'b0;
						end
					end
				ULMC_ADDR_LINE: s_next.lc = ulmc_line_t'(pwdata[7:0]);
				ULMC_ADDR_MODEM: s_next.mc = ulmc_modem_t'(pwdata[7:0]);
				ULMC_ADDR_FEAT: s_next.feat = pwdata[7:0];
				ULMC_ADDR_TRIG:
					if (s_reg.feat[ULMC_FEAT_TARGET]) // RULE_02
						s_next.prog_tx = pwdata[6:0];
					else
						s_next.prog_rx = pwdata[6:0];
				ULMC_ADDR_FLOW:
				begin
					s_next.sw_flow = pwdata[0];
					s_next.xon = pwdata[15:8];
					s_next.xoff = pwdata[23:16];
				end
				default: ;
			endcase
		end

		// Receiver, sampling at the middle of each bit
		if (s_reg.tick)
		begin
			s_next.rx_cnt = s_reg.rx_cnt + 6'h01;
			case (s_reg.rx_st)
				RX_IDLE:
					if (!s_reg.rx_in)
					begin
						s_next.rx_st = RX_START;
						s_next.rx_cnt = '0;
					end
				RX_START:
					if (s_reg.rx_cnt == ULMC_MID_LAST)
					begin
						s_next.rx_st = s_reg.rx_in ? RX_IDLE : RX_DATA;
						s_next.rx_cnt = '0;
						s_next.rx_bit = '0;
						s_next.rx_sh = '0;
					end
				RX_DATA:
					if (s_reg.rx_cnt == ULMC_BIT_LAST)
					begin
						s_next.rx_cnt = '0;
						s_next.rx_sh[s_reg.rx_bit] = s_reg.rx_in;
						s_next.rx_bit = s_reg.rx_bit + 3'h1;
						if (s_reg.rx_bit == ulmc_last_bit(s_reg.lc)) // RULE_03
							s_next.rx_st = s_reg.lc.pen ? RX_PAR : RX_STOP; // RULE_05
					end
				RX_PAR:
					if (s_reg.rx_cnt == ULMC_BIT_LAST)
					begin
						s_next.rx_cnt = '0;
						s_next.rx_st = RX_STOP;
						if (s_reg.rx_in != ulmc_parity(s_reg.rx_sh, s_reg.lc)) // RULE_06 RULE_07
							s_next.perr = 1'b1;
					end
				RX_STOP:
					if (s_reg.rx_cnt == ULMC_BIT_LAST)
					begin
						s_next.rx_st = RX_IDLE;
						if (!s_reg.rx_in)
						begin
							s_next.ferr = 1'b1;
							s_next.brk_det = s_reg.rx_sh == '0;
						end
						if (s_reg.sw_flow && s_reg.rx_sh == s_reg.xoff)
							s_next.halted = 1'b1;
						else if (s_reg.mc.any_resume || (s_reg.sw_flow && s_reg.rx_sh == s_reg.xon)) // RULE_16
							s_next.halted = 1'b0;
						// Flow characters are consumed, everything else is stored unless the FIFO is full
						if (!(s_reg.sw_flow && (s_reg.rx_sh == s_reg.xon || s_reg.rx_sh == s_reg.xoff))) // RULE_17
						begin
							if (int'(s_reg.count) >= (s_reg.fifo_en ? FIFO_DEPTH : 1))
								s_next.overrun = 1'b1;
							else
								push = 1'b1;
						end
					end
				default: s_next.rx_st = RX_IDLE;
			endcase
		end

		// Receive FIFO; depth must be a power of two so the pointers wrap
		if (flush)
		begin
			s_next.wr_ptr = '0;
			s_next.rd_ptr = '0;
			s_next.count = '0;
		end
		else
		begin
			if (push)
			begin
				s_next.mem[s_reg.wr_ptr] = s_reg.rx_sh;
				s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
			end
			if (pop)
				s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
			s_next.count = s_reg.count + (PW+1)'(push) - (PW+1)'(pop);
		end

		// Pins: loopback parks txd and the modem pins inactive, not the interrupt enable
		s_next.txd = s_reg.mc.loop ? 1'b1 : (s_reg.mc.ir ? tx_ir && !s_reg.lc.brk : tx_line); // RULE_08 RULE_18
		s_next.dtr_n = s_reg.mc.loop || !s_reg.mc.dtr; // RULE_10
		s_next.rts_n = s_reg.mc.loop || (s_reg.feat[ULMC_FEAT_HALF_DUPLEX] ? !(tx_busy || s_reg.thr_full)
			: !s_reg.mc.rts); // RULE_11
		s_next.op2_n = s_reg.mc.loop || !s_reg.mc.op2; // RULE_13
		s_next.irq_en = s_reg.mc.op2; // RULE_13
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0; // RULE_23
			s_reg.txd <= 1'b1;
			s_reg.dtr_n <= 1'b1;
			s_reg.rts_n <= 1'b1;
			s_reg.op2_n <= 1'b1;
			s_reg.rx_in <= 1'b1;
			// Synchronisers start at the idle pin level so no false start bit or ring follows reset
			s_reg.rx_s1 <= 1'b1;
			s_reg.rx_s2 <= 1'b1;
			s_reg.ring_s1 <= 1'b1;
			s_reg.ring_s2 <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign txd = s_reg.txd;
	assign terminal_ready_n = s_reg.dtr_n;
	assign request_send_n = s_reg.rts_n;
	assign spare_output_two_n = s_reg.op2_n;
	assign irq_out_en = s_reg.irq_en;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence presc_gap_s;
		!(pre_tick && s_reg.mc.presc) [*3];
	endsequence
	presc_div_a: assert property (s_reg.mc.presc && pre_tick |=> presc_gap_s) // RULE_20
		else $error("prescaler tick spacing below four");
	break_low_a: assert property (s_reg.lc.brk && !s_reg.mc.loop |=> !txd) // RULE_08
		else $error("break not driving txd low");
	dtr_pin_a: assert property (!s_reg.mc.loop |=> terminal_ready_n == !$past(s_reg.mc.dtr)) // RULE_10
		else $error("terminal ready pin wrong");
	op2_pin_a: assert property (##1 irq_out_en == $past(s_reg.mc.op2) && (spare_output_two_n || irq_out_en)) // RULE_13
		else $error("interrupt enable or spare output wrong");
	ir_idle_a: assert property (s_reg.mc.ir && !s_reg.mc.loop && !tx_busy |=> !txd) // RULE_19
		else $error("infrared output not idle low");
	data_ready_a: assert property (setup && paddr == ULMC_ADDR_LSTAT |=>
		pready && prdata[0] == ($past(s_reg.count) != '0)) // RULE_21
		else $error("data ready bit mismatch");
	dlab_write_a: assert property (wr && paddr == ULMC_ADDR_DATA && s_reg.lc.dlab |=>
		s_reg.div[7:0] == $past(pwdata[7:0]) && s_reg.thr_full == $past(tx_start ? 1'b0 : s_reg.thr_full)) // RULE_09
		else $error("divisor access misrouted");
	fifo_keep_a: assert property (wr && paddr == ULMC_ADDR_FIFO && !s_reg.lc.dlab && !pwdata[0] |=>
		$stable(s_reg.rx_sel) && $stable(s_reg.tx_sel) && !s_reg.fifo_en) // RULE_22
		else $error("trigger fields changed without fifo enable");
endmodule // ulmc_top

// *** verilog/ulmc_tx.sv ***
// Transmit serializer: start, 5..8 data bits LSB first, optional parity, stop period.
// Assumes a one-cycle 16x tick and a start request from logic on the same clock.
`timescale 1ns/10ps
module ulmc_tx
	import ulmc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic tick,
	input wire logic start,
	input wire logic [7:0] data,
	input wire ulmc_line_t line,
	// Serial out
	output logic serial,
	output logic ir_pulse,
	output logic busy
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulmc_tx_st_t;
	typedef struct packed {
		ulmc_tx_st_t st;
		logic [5:0] cnt;
		logic [2:0] bitn;
		logic [7:0] sh;
		logic serial;
		logic ir;
		logic busy;
	} ulmc_tx_t;
	ulmc_tx_t s_reg, s_next;
	logic [5:0] stop_last;

	always_comb
	begin
		s_next = s_reg;
		stop_last = !line.stop_long ? ULMC_BIT_LAST : (line.wlen == 2'h0 ? ULMC_STOP15_LAST : ULMC_STOP2_LAST); // RULE_04
		case (s_reg.st)
			TX_IDLE:
				if (start)
				begin
					s_next.st = TX_START;
					s_next.cnt = '0;
					s_next.sh = data;
					s_next.serial = 1'b0;
				end
			TX_STOP:
				if (tick)
				begin
					s_next.cnt = s_reg.cnt + 6'h01;
					if (s_reg.cnt == stop_last)
						s_next.st = TX_IDLE;
				end
			default:
				if (tick)
				begin
					s_next.cnt = s_reg.cnt + 6'h01;
					if (s_reg.cnt == ULMC_BIT_LAST)
					begin
						s_next.cnt = '0;
						if (s_reg.st == TX_START)
						begin
							s_next.st = TX_DATA;
							s_next.bitn = '0;
							s_next.serial = s_reg.sh[0];
						end
						else if (s_reg.st == TX_DATA && s_reg.bitn != ulmc_last_bit(line)) // RULE_03
						begin
							s_next.bitn = s_reg.bitn + 3'h1;
							s_next.serial = s_reg.sh[s_reg.bitn + 3'h1];
						end
						else if (s_reg.st == TX_DATA && line.pen) // RULE_05
						begin
							s_next.st = TX_PAR;
							s_next.serial = ulmc_parity(s_reg.sh, line); // RULE_06 RULE_07
						end
						else
						begin
							s_next.st = TX_STOP;
							s_next.serial = 1'b1;
						end
					end
				end
		endcase
		s_next.busy = s_next.st != TX_IDLE;
		// Short high pulse for each zero bit; no pulse while idle
		s_next.ir = s_next.busy && !s_next.serial && s_next.cnt < ULMC_IR_PULSE; // RULE_19
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0;
			s_reg.serial <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign serial = s_reg.serial;
	assign ir_pulse = s_reg.ir;
	assign busy = s_reg.busy;
endmodule // ulmc_tx
